// file: core/shift_lever_source_selector.sv
// Shift lever source selector: decodes two lever sources and chooses direction and range.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps

// Operation
// - Without range information, request automatic shifting from first up to the top range.
// - Pulse lever steps range on up and down pulses; direction from levels.
// - Pattern lever maps each configured six-wire pattern to one position.
// - Forward/reverse lever gives direction from levels and no range signals.
// - The lever position may come from the received drive request message.
// - Two lever sources may be configured, one master and one slave.
// - Bus master pairs with any wired slave; pattern or pulse with forward/reverse.
// - Bus master with lever byte all ones hands control to the wired slave.
// - Bus master with any other lever byte uses that byte as position.
// - Pattern master in forward or reverse supplies direction and range.
// - Pattern master in neutral: direction from slave, range from master.
// - Optionally hold neutral after a source change until the new source is neutral.
// - Optionally hold neutral after a source change until standstill.
// - Optional debounce before accepting a new direction and a new range.
module shift_lever_source_selector (
	input wire logic CLK_SYS_I,
	input wire logic SYS_RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire lever_sel_pkg::lever_in_t MASTER_LEVER_I,
	input wire lever_sel_pkg::lever_in_t SLAVE_LEVER_I,
	input wire logic STANDSTILL_I,
	output lever_sel_pkg::request_t REQUEST_O,
	output logic CONFIG_ERR_O
);
	import lever_sel_pkg::*;

	logic [31:0] config_reg;
	logic [12:0] pattern [NUM_PATTERNS];
	logic [31:0] debounce_reg;
	logic [31:0] bus_msg;
	logic [3:0] pulse_rng_m;
	logic [3:0] pulse_rng_s;
	logic prev_up_m, prev_down_m, prev_up_s, prev_down_s;
	lock_t lock_state;
	logic prev_from_slave;
	logic valid_seen;
	dir_t dir_out;
	logic [3:0] rng_out;
	logic [15:0] deb_ms_dir, deb_ms_rng;
	logic [31:0] tick_cnt;

	// APB decode: zero wait states, unmapped addresses answer with an error.
	wire apb_access = PSEL_I && PENABLE_I;
	wire sel_cfg = (PADDR_I == OFF_CONFIG);
	wire sel_deb = (PADDR_I == OFF_DEBOUNCE);
	wire sel_bus = (PADDR_I == OFF_BUS_MSG);
	wire sel_sta = (PADDR_I == OFF_STATUS);
	wire [7:0] pat_off = PADDR_I - OFF_PATTERN0;
	wire sel_pat = (PADDR_I >= OFF_PATTERN0) && (PADDR_I < OFF_DEBOUNCE) && (PADDR_I[1:0] == 2'h0);
	wire [2:0] pat_idx = pat_off[4:2];
	wire mapped = sel_cfg || sel_deb || sel_bus || sel_sta || sel_pat;
	wire wr_en = apb_access && PWRITE_I && mapped;
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = apb_access && !mapped;

	// Configuration fields.
	src_t master_src, slave_src;
	assign master_src = src_t'(config_reg[CFG_MASTER_LSB +: 2]);
	assign slave_src = src_t'(config_reg[CFG_SLAVE_LSB +: 2]);
	wire dual = config_reg[CFG_DUAL_BIT];
	wire lock_neu_en = config_reg[CFG_LOCK_NEU_BIT];
	wire lock_still_en = config_reg[CFG_LOCK_STILL_BIT];
	wire deb_en = config_reg[CFG_DEB_EN_BIT];
	wire [3:0] max_range = config_reg[CFG_MAXRNG_LSB +: 4];

	// Pairing check; an illegal pairing falls back to the master alone.
	wire pair_ok = (master_src == SRC_BUS && slave_src != SRC_BUS) ||
		((master_src == SRC_PATTERN || master_src == SRC_PULSE) && slave_src == SRC_FWDREV);
	wire use_dual = dual && pair_ok;
	assign CONFIG_ERR_O = dual && !pair_ok;

	// Decode one lever of the given type into direction, range and validity.
	function automatic logic [6:0] decode(input src_t src, input lever_in_t lv,
		input logic [3:0] prng);
		logic [6:0] res;
		res = {DIR_NEUTRAL, 4'h0, 1'b0};
		case (src)
			SRC_PULSE, SRC_FWDREV: begin
				// Both levels at once is treated as neutral, never as a direction.
				if (lv.fwd && !lv.rev) begin
					res[6:5] = DIR_FORWARD;
				end else if (lv.rev && !lv.fwd) begin
					res[6:5] = DIR_REVERSE;
				end
				res[4:1] = (src == SRC_PULSE) ? prng : 4'h0;
				res[0] = 1'b1;
			end
			SRC_PATTERN: begin
				for (int i = 0; i < NUM_PATTERNS; i++) begin
					if (pattern[i][PAT_VALID_BIT] && pattern[i][PAT_WIRES_LSB +: 6] == lv.wires) begin
						res = {pattern[i][PAT_DIR_LSB +: 2], pattern[i][PAT_RNG_LSB +: 4], 1'b1};
					end
				end
			end
			default: begin
				// The bus byte: bits 5:4 direction, 3:0 range.
				res = {bus_msg[5:4], bus_msg[3:0], 1'b1};
			end
		endcase
		return res;
	endfunction

	wire [6:0] dec_m = decode(master_src, MASTER_LEVER_I, pulse_rng_m);
	wire [6:0] dec_s = decode(slave_src, SLAVE_LEVER_I, pulse_rng_s);
	wire bus_handover = (bus_msg[7:0] == BUS_TAKE_SLAVE);

	// Source selection: direction and range may come from different levers.
	logic [1:0] sel_dir;
	logic [3:0] sel_rng;
	logic sel_valid, from_slave;
	always_comb begin
		sel_dir = dec_m[6:5];
		sel_rng = dec_m[4:1];
		sel_valid = dec_m[0];
		from_slave = 1'b0;
		if (master_src == SRC_BUS && bus_handover) begin
			if (use_dual) begin
				{sel_dir, sel_rng, sel_valid} = dec_s;
				from_slave = 1'b1;
			end else begin
				sel_valid = 1'b0;
			end
		end else if (use_dual && master_src != SRC_BUS && dec_m[6:5] == DIR_NEUTRAL) begin
			sel_dir = dec_s[6:5];
			from_slave = 1'b1;
		end
	end
	// Range from a pattern master whether forward, reverse or neutral. keeps both.

	// No range source means automatic up to the configured top range.
	wire no_range = (master_src == SRC_FWDREV) || (from_slave && slave_src == SRC_FWDREV &&
		master_src == SRC_BUS);
	wire [3:0] eff_rng = no_range ? max_range : sel_rng;

	// Pulse levers step the range on rising edges of up and down, saturating.
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			pulse_rng_m <= 4'h1;
			pulse_rng_s <= 4'h1;
			{prev_up_m, prev_down_m, prev_up_s, prev_down_s} <= 4'h0;
		end else begin
			{prev_up_m, prev_down_m} <= {MASTER_LEVER_I.up, MASTER_LEVER_I.down};
			{prev_up_s, prev_down_s} <= {SLAVE_LEVER_I.up, SLAVE_LEVER_I.down};
			if (MASTER_LEVER_I.up && !prev_up_m && pulse_rng_m < max_range) begin
				pulse_rng_m <= pulse_rng_m + 4'h1;
			end else if (MASTER_LEVER_I.down && !prev_down_m && pulse_rng_m > 4'h1) begin
				pulse_rng_m <= pulse_rng_m - 4'h1;
			end
			if (SLAVE_LEVER_I.up && !prev_up_s && pulse_rng_s < max_range) begin
				pulse_rng_s <= pulse_rng_s + 4'h1;
			end else if (SLAVE_LEVER_I.down && !prev_down_s && pulse_rng_s > 4'h1) begin
				pulse_rng_s <= pulse_rng_s - 4'h1;
			end
		end
	end

	// Source-change interlock: a change arms a neutral hold until the conditions clear.
	wire src_changed = (from_slave != prev_from_slave) && (lock_neu_en || lock_still_en);
	wire neu_ok = !lock_neu_en || sel_dir == DIR_NEUTRAL;
	wire still_ok = !lock_still_en || STANDSTILL_I;
	logic neu_seen;
	lock_t next_lock;
	always_comb begin
		next_lock = lock_state;
		case (lock_state)
			LK_FREE: if (src_changed) next_lock = LK_HOLD;
			LK_HOLD: if (neu_ok) next_lock = LK_WAIT;
			LK_WAIT: if (still_ok || src_changed) next_lock = src_changed ? LK_HOLD : LK_FREE;
			default: next_lock = LK_FREE;
		endcase
	end
	assign neu_seen = (lock_state == LK_FREE) && !src_changed;

	// Debounce counters in milliseconds; direction and range count apart.
	wire ms_tick = (tick_cnt == DEB_TICK_CYCLES - 1);
	wire dir_new = (sel_dir != dir_out);
	wire rng_new = (eff_rng != rng_out);
	wire dir_take = !deb_en || deb_ms_dir >= debounce_reg[15:0];
	wire rng_take = !deb_en || deb_ms_rng >= debounce_reg[31:16];

	// Output registers, updated on every rising clock edge.
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			tick_cnt <= 32'h0;
			deb_ms_dir <= 16'h0;
			deb_ms_rng <= 16'h0;
			dir_out <= DIR_NEUTRAL;
			rng_out <= 4'h0;
			valid_seen <= 1'b0;
			lock_state <= LK_FREE;
			prev_from_slave <= 1'b0;
			REQUEST_O <= '0;
		end else begin
			tick_cnt <= ms_tick ? 32'h0 : tick_cnt + 32'h1;
			deb_ms_dir <= !dir_new ? 16'h0 : (ms_tick ? deb_ms_dir + 16'h1 : deb_ms_dir);
			deb_ms_rng <= !rng_new ? 16'h0 : (ms_tick ? deb_ms_rng + 16'h1 : deb_ms_rng);
			lock_state <= next_lock;
			prev_from_slave <= from_slave;
			valid_seen <= valid_seen || sel_valid;
			if (sel_valid && dir_new && dir_take) dir_out <= dir_t'(sel_dir);
			if (sel_valid && rng_new && rng_take) rng_out <= eff_rng;
			REQUEST_O.dir <= (valid_seen && neu_seen && sel_valid) ? dir_out : DIR_NEUTRAL;
			REQUEST_O.range <= rng_out;
			REQUEST_O.auto_mode <= no_range;
			REQUEST_O.from_slave <= from_slave;
		end
	end

	// Register writes; the bus message register models the received lever byte.
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			config_reg <= CONFIG_RESET;
			debounce_reg <= DEBOUNCE_RESET;
			bus_msg <= BUS_MSG_RESET;
			for (int i = 0; i < NUM_PATTERNS; i++) pattern[i] <= 13'h0;
		end else if (wr_en) begin
			if (sel_cfg) config_reg <= PWDATA_I;
			else if (sel_deb) debounce_reg <= PWDATA_I;
			else if (sel_bus) bus_msg <= PWDATA_I;
			else if (sel_pat) pattern[pat_idx] <= PWDATA_I[12:0];
		end
	end

	// Read mux; status shows the live selection and interlock.
	// Fields are packed so that the word is exactly 32 bits, with no silent padding.
	wire [31:0] status_word = {21'h0, CONFIG_ERR_O, lock_state, from_slave, rng_out, dir_out};
	always_comb begin
		PRDATA_O = 32'h0;
		if (sel_cfg) PRDATA_O = config_reg;
		else if (sel_deb) PRDATA_O = debounce_reg;
		else if (sel_bus) PRDATA_O = bus_msg;
		else if (sel_sta) PRDATA_O = status_word;
		else if (sel_pat) PRDATA_O = {19'h0, pattern[pat_idx]};
	end

	// Checks.
	a_reset_neutral: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		!valid_seen |=> REQUEST_O.dir == DIR_NEUTRAL) else $error("no neutral before valid");
	a_hold_neutral: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		lock_state != LK_FREE |=> REQUEST_O.dir == DIR_NEUTRAL) else $error("lock not neutral");
	a_still_wait: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		lock_state == LK_WAIT && !STANDSTILL_I && lock_still_en && !src_changed |=>
		lock_state == LK_WAIT) else $error("left wait without standstill");
	a_bus_handover: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		master_src == SRC_BUS && bus_handover && use_dual |=> REQUEST_O.from_slave)
		else $error("no handover to slave");
	a_bus_direct: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		master_src == SRC_BUS && !bus_handover |=> !REQUEST_O.from_slave)
		else $error("bus byte ignored");
	a_pat_neutral: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		use_dual && master_src == SRC_PATTERN && dec_m[6:5] == DIR_NEUTRAL |=>
		REQUEST_O.from_slave) else $error("neutral master kept direction");
	a_pat_drive: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		master_src == SRC_PATTERN && dec_m[6:5] != DIR_NEUTRAL |=> !REQUEST_O.from_slave)
		else $error("driving master overridden");
	a_auto_range: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		master_src == SRC_FWDREV |=> REQUEST_O.auto_mode) else $error("no auto mode");
	a_pair_legal: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		use_dual |-> master_src != slave_src) else $error("illegal pairing used");
	a_pulse_step: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		MASTER_LEVER_I.up && !prev_up_m && pulse_rng_m < max_range |=>
		pulse_rng_m == $past(pulse_rng_m) + 4'h1) else $error("pulse did not step");
endmodule

// file: core/lever_sel_pkg.sv
// Package with register map, field layouts, types and timing constants of the lever selector.
package lever_sel_pkg;

	// Register byte offsets.
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_PATTERN0 = 8'h04;
	localparam logic [7:0] OFF_DEBOUNCE = 8'h1c;
	localparam logic [7:0] OFF_BUS_MSG = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	localparam int NUM_PATTERNS = 6;

	// Fields of the configuration register.
	localparam int CFG_MASTER_LSB = 0;
	localparam int CFG_SLAVE_LSB = 2;
	localparam int CFG_DUAL_BIT = 4;
	localparam int CFG_LOCK_NEU_BIT = 5;
	localparam int CFG_LOCK_STILL_BIT = 6;
	localparam int CFG_DEB_EN_BIT = 7;
	localparam int CFG_MAXRNG_LSB = 8;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0400;

	// Pattern register fields: wire code, direction, range and valid bit.
	localparam int PAT_WIRES_LSB = 0;
	localparam int PAT_DIR_LSB = 6;
	localparam int PAT_RNG_LSB = 8;
	localparam int PAT_VALID_BIT = 12;

	// Bus message fields: lever byte, direction bits and range in the low nibble.
	localparam logic [7:0] BUS_TAKE_SLAVE = 8'hff;
	localparam logic [31:0] BUS_MSG_RESET = 32'h0000_00ff;

	// Clock in MHz, debounce tick length in microseconds and the cycle count per millisecond.
	localparam int CLK_MHZ = 100;
	localparam int DEB_TICK_US = 1000;
	localparam int DEB_TICK_CYCLES = DEB_TICK_US * CLK_MHZ;
	localparam logic [31:0] DEBOUNCE_RESET = 32'h0000_0000;

	// Lever source types.
	typedef enum logic [1:0] {
		SRC_PULSE = 2'h0,
		SRC_PATTERN = 2'h1,
		SRC_FWDREV = 2'h2,
		SRC_BUS = 2'h3
	} src_t;

	// Direction requests.
	typedef enum logic [1:0] {
		DIR_NEUTRAL = 2'h0,
		DIR_FORWARD = 2'h1,
		DIR_REVERSE = 2'h2
	} dir_t;

	// Interlock states, one-hot.
	typedef enum logic [2:0] {
		LK_FREE = 3'h1,
		LK_HOLD = 3'h2,
		LK_WAIT = 3'h4
	} lock_t;

	// Wired lever inputs travelling together.
	typedef struct packed {
		logic fwd;
		logic rev;
		logic up;
		logic down;
		logic [5:0] wires;
	} lever_in_t;

	// Request presented to the shift logic.
	typedef struct packed {
		dir_t dir;
		logic [3:0] range;
		logic auto_mode;
		logic from_slave;
	} request_t;

endpackage

// file: tb/lever_model.sv
// Behavioural model of the driver levers and the vehicle standstill sensor.
`timescale 1ns/10ps
module lever_model
	import lever_sel_pkg::*;
(
	input wire logic clk_i,
	output lever_in_t master_o,
	output lever_in_t slave_o,
	output logic standstill_o
);
	// Both levers rest in neutral with the vehicle moving, the harder case for the locks.
	initial begin
		master_o = '0;
		slave_o = '0;
		standstill_o = 1'b0;
	end

	// All wires of a lever move in one step, so no half-way pattern is ever shown.
	task automatic set_lever(input logic sel, input logic f, input logic r, input logic [5:0] w);
		@(posedge clk_i);
		if (sel) begin
			slave_o <= '{fwd: f, rev: r, up: 1'b0, down: 1'b0, wires: w};
		end else begin
			master_o <= '{fwd: f, rev: r, up: 1'b0, down: 1'b0, wires: w};
		end
	endtask

	// One-cycle bump on the master, then a gap so that the next bump is a new edge.
	task automatic pulse(input logic up);
		@(posedge clk_i);
		master_o.up <= up;
		master_o.down <= !up;
		@(posedge clk_i);
		master_o.up <= 1'b0;
		master_o.down <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	// Standstill is a plain level from the speed logic.
	task automatic set_still(input logic s);
		@(posedge clk_i);
		standstill_o <= s;
	endtask
endmodule

// file: tb/shift_lever_source_selector_bench.sv
// Self-checking bench for the lever source selector, driven over APB.
`timescale 1ns/10ps
module shift_lever_source_selector_bench;
	import lever_sel_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic err;
	logic cfg_err;
	logic standstill;
	lever_in_t master_lever;
	lever_in_t slave_lever;
	request_t request;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;

	// Free-running 100 MHz system clock.
	always #5 clk = ~clk;

	shift_lever_source_selector i_shift_lever_source_selector (
		.CLK_SYS_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .MASTER_LEVER_I(master_lever),
		.SLAVE_LEVER_I(slave_lever), .STANDSTILL_I(standstill), .REQUEST_O(request),
		.CONFIG_ERR_O(cfg_err)
	);

	lever_model i_lever_model (
		.clk_i(clk), .master_o(master_lever), .slave_o(slave_lever), .standstill_o(standstill)
	);

	// Ends the run with the counts and the verdict.
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// A hung handshake would stall forever, so a cycle ceiling cuts the run short.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("unexpected at %0t: timeout", $time);
			final_report;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is seen high at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		forever begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// The request trails the lever by two edges; three leave margin.
	task automatic req(input logic [1:0] d, input logic [3:0] r, input string m);
		repeat (3) @(posedge clk);
		#1;
		chk(request.dir, d, m);
		if (r !== 4'hf) chk(request.range, r, m);
	endtask

	task automatic test_end(input string n);
		$display("test %s done, mismatches %0d", n, errors);
	endtask

	// Main sequence of tests.
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 chk(request, 8'h00, "reset request");
		apb(0, OFF_CONFIG, 0);
		chk(rd, CONFIG_RESET, "config reset");
		apb(0, OFF_BUS_MSG, 0);
		chk(rd, BUS_MSG_RESET, "bus reset");
		apb(0, OFF_DEBOUNCE, 0);
		chk(rd, DEBOUNCE_RESET, "debounce reset");
		apb(0, 8'h40, 0);
		chk({rd[30:0], err}, 32'h1, "unmapped");
		test_end("reset");
		// Forward/reverse lever alone: levels only, automatic range.
		apb(1, OFF_CONFIG, 32'h0000_0402);
		i_lever_model.set_lever(0, 1, 0, 0);
		req(DIR_FORWARD, 4'hf, "fr fwd");
		chk(request.auto_mode, 1'b1, "fr auto");
		i_lever_model.set_lever(0, 1, 1, 0);
		req(DIR_NEUTRAL, 4'hf, "fr both");
		i_lever_model.set_lever(0, 0, 1, 0);
		req(DIR_REVERSE, 4'hf, "fr rev");
		test_end("fwdrev");
		// Bump lever: range saturates at 1 and at the maximum of 4.
		apb(1, OFF_CONFIG, 32'h0000_0400);
		i_lever_model.set_lever(0, 1, 0, 0);
		repeat (5) i_lever_model.pulse(0);
		req(DIR_FORWARD, 4'h1, "bump floor");
		i_lever_model.pulse(1);
		req(DIR_FORWARD, 4'h2, "bump up");
		repeat (5) i_lever_model.pulse(1);
		req(DIR_FORWARD, 4'h4, "bump ceiling");
		test_end("bump");
		// Pattern lever: F3 on code 05, N2 on code 0a, nothing on 3f.
		apb(1, OFF_PATTERN0, 32'h0000_1345);
		apb(1, OFF_PATTERN0 + 8'h04, 32'h0000_120a);
		apb(1, OFF_CONFIG, 32'h0000_0401);
		i_lever_model.set_lever(0, 0, 0, 6'h05);
		req(DIR_FORWARD, 4'h3, "pattern F3");
		i_lever_model.set_lever(0, 0, 0, 6'h3f);
		req(DIR_NEUTRAL, 4'hf, "pattern none");
		test_end("pattern");
		// Pattern master with forward/reverse slave, then an illegal pairing.
		apb(1, OFF_CONFIG, 32'h0000_0419);
		#1 chk(cfg_err, 1'b0, "pair ok");
		i_lever_model.set_lever(0, 0, 0, 6'h0a);
		i_lever_model.set_lever(1, 0, 1, 0);
		req(DIR_REVERSE, 4'h2, "neutral master");
		i_lever_model.set_lever(0, 0, 0, 6'h05);
		req(DIR_FORWARD, 4'h3, "fwd master");
		apb(1, OFF_CONFIG, 32'h0000_0411);
		#1 chk(cfg_err, 1'b1, "pair bad");
		test_end("dual pattern");
		// Bus master with bump slave: lever byte ff hands over to the wire.
		apb(1, OFF_CONFIG, 32'h0000_0413);
		apb(1, OFF_BUS_MSG, 32'h0000_0023);
		req(DIR_REVERSE, 4'h3, "bus R3");
		chk(request.from_slave, 1'b0, "bus own");
		i_lever_model.set_lever(1, 1, 0, 0);
		apb(1, OFF_BUS_MSG, 32'h0000_00ff);
		req(DIR_FORWARD, 4'hf, "bus ff");
		chk(request.from_slave, 1'b1, "bus slave");
		apb(1, OFF_BUS_MSG, 32'h0000_0013);
		req(DIR_FORWARD, 4'h3, "bus F3");
		test_end("bus");
		// Neutral lock: the new source must pass neutral first.
		apb(1, OFF_CONFIG, 32'h0000_0433);
		apb(1, OFF_BUS_MSG, 32'h0000_00ff);
		req(DIR_NEUTRAL, 4'hf, "lock held");
		i_lever_model.set_lever(1, 0, 0, 0);
		i_lever_model.set_lever(1, 1, 0, 0);
		req(DIR_FORWARD, 4'hf, "lock freed");
		// Standstill lock: held until the vehicle stops.
		apb(1, OFF_CONFIG, 32'h0000_0453);
		apb(1, OFF_BUS_MSG, 32'h0000_0013);
		req(DIR_NEUTRAL, 4'hf, "still held");
		i_lever_model.set_still(1);
		req(DIR_FORWARD, 4'h3, "still freed");
		apb(0, OFF_STATUS, 0);
		chk(rd, 32'h0000_008d, "status word");
		test_end("locks");
		final_report;
	end
endmodule
